// File: verilog/crs_regset.sv
`timescale 1ns/1ps
module crs_regset import crs_pkg::*; #(
	parameter int unsigned BW = CRS_BYTE_W,
	parameter int unsigned W = CRS_WORD_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire crs_wr_t i_wr_sel,
	input wire logic [W-1:0] i_wr_data,
	input wire logic i_direct,
	input wire logic [BW-1:0] i_direct_low,
	input wire logic i_idx_en,
	input wire crs_ptr_t i_idx_ptr,
	input wire crs_adj_t i_idx_adj,
	input wire crs_off_t i_idx_off_sel,
	input wire logic [W-1:0] i_idx_const,
	input wire logic [W-1:0] i_idx_regoff,
	input wire crs_stk_t i_stk_op,
	input wire logic i_stk_explicit,
	input wire logic i_stk_frame,
	input wire logic i_fetch_adv,
	input wire logic i_nmi_req,
	output logic [W-1:0] o_addr,
	output logic o_addr_valid,
	output logic [BW-1:0] o_high,
	output logic [BW-1:0] o_low,
	output logic [W-1:0] o_pair,
	output logic [BW-1:0] o_page,
	output logic [W-1:0] o_first,
	output logic [W-1:0] o_second,
	output logic [W-1:0] o_soft,
	output logic [W-1:0] o_frame,
	output logic [W-1:0] o_fetch,
	output logic o_nmi
);
	// separate accumulators; no reset on data registers except the page register
	logic [BW-1:0] high_reg, high_next, low_reg, low_next;
	logic [BW-1:0] page_reg, page_next;
	logic [W-1:0] first_reg, first_next, second_reg, second_next;
	logic [W-1:0] soft_reg, soft_next, frame_reg, frame_next, fetch_reg, fetch_next;
	logic nmi_arm_reg, nmi_arm_next;
	logic [W-1:0] addr_reg, addr_next;
	logic addr_valid_reg, addr_valid_next;
	logic nmi_reg, nmi_next;
	logic nmi_s1_reg, nmi_s2_reg, nmi_s3_reg, nmi_filt_reg, nmi_filt_next;
	logic [W-1:0] idx_base, ea, wb, stk_sp, stk_addr, stk_sp_next;
	logic wb_en, stk_we;
	crs_stk_t stk_op_eff;

	// any pointer as base; fetch pointer relative base
	always_comb begin
		case (i_idx_ptr)
			CRS_P_FIRST: idx_base = first_reg;
			CRS_P_SECOND: idx_base = second_reg;
			CRS_P_SOFT: idx_base = soft_reg;
			CRS_P_FRAME: idx_base = frame_reg;
			CRS_P_FETCH: idx_base = fetch_reg;
			default: idx_base = first_reg;
		endcase
	end

	crs_ea_unit #(.W(W)) u_ea (
		.i_base(idx_base),
		.i_adj(i_idx_en ? i_idx_adj : CRS_X_NONE),
		.i_off_sel(i_idx_off_sel),
		.i_const_off(i_idx_const),
		.i_reg_off(i_idx_regoff),
		.o_ea(ea),
		.o_wb(wb),
		.o_wb_en(wb_en)
	);

	// soft stack moves only when named explicitly
	always_comb begin
		stk_sp = i_stk_frame ? frame_reg : soft_reg;
		stk_op_eff = (i_stk_frame || i_stk_explicit) ? i_stk_op : CRS_S_NONE;
	end

	// push and pull on both stacks
	crs_stack_unit #(.W(W)) u_stk (
		.i_sp(stk_sp),
		.i_op(stk_op_eff),
		.o_addr(stk_addr),
		.o_sp_next(stk_sp_next),
		.o_sp_we(stk_we)
	);

	always_comb begin
		high_next = high_reg;
		low_next = low_reg;
		page_next = page_reg;
		first_next = first_reg;
		second_next = second_reg;
		soft_next = soft_reg;
		frame_next = frame_reg;
		fetch_next = i_fetch_adv ? fetch_reg + CRS_ONE : fetch_reg;
		nmi_arm_next = nmi_arm_reg;
		case (i_wr_sel)
			CRS_W_HIGH: high_next = i_wr_data[BW-1:0];
			CRS_W_LOW: low_next = i_wr_data[BW-1:0];
			CRS_W_PAIR: begin
				high_next = i_wr_data[W-1:BW];
				low_next = i_wr_data[BW-1:0];
			end
			CRS_W_PAGE: page_next = i_wr_data[BW-1:0];
			CRS_W_FIRST: first_next = i_wr_data;
			CRS_W_SECOND: second_next = i_wr_data;
			CRS_W_SOFT: soft_next = i_wr_data;
			CRS_W_FRAME: begin
				frame_next = i_wr_data;
				nmi_arm_next = 1'b1;
			end
			CRS_W_FETCH: fetch_next = i_wr_data;
			default: begin
			end
		endcase
		if (i_idx_en && wb_en) begin
			case (i_idx_ptr)
				CRS_P_FIRST: first_next = wb;
				CRS_P_SECOND: second_next = wb;
				CRS_P_SOFT: soft_next = wb;
				CRS_P_FRAME: frame_next = wb;
				default: begin
				end
			endcase
		end
		if (stk_we) begin
			if (i_stk_frame) begin
				frame_next = stk_sp_next;
			end else begin
				soft_next = stk_sp_next;
			end
		end
		if (i_direct) begin
			addr_next = {page_reg, i_direct_low};
			addr_valid_next = 1'b1;
		end else if (stk_op_eff != CRS_S_NONE) begin
			addr_next = stk_addr;
			addr_valid_next = 1'b1;
		end else if (i_idx_en) begin
			addr_next = ea;
			addr_valid_next = 1'b1;
		end else begin
			addr_next = addr_reg;
			addr_valid_next = 1'b0;
		end
		// The pin level is taken only once the last two stages agree, so a metastable
		// sample or a single-cycle glitch never reaches the interrupt output.
		nmi_filt_next = (nmi_s2_reg == nmi_s3_reg) ? nmi_s2_reg : nmi_filt_reg;
		nmi_next = nmi_filt_reg && nmi_arm_reg;
	end

	always_ff @(posedge i_clk) begin
		high_reg <= high_next;
		low_reg <= low_next;
		first_reg <= first_next;
		second_reg <= second_next;
		soft_reg <= soft_next;
		frame_reg <= frame_next;
		fetch_reg <= fetch_next;
		addr_reg <= addr_next;
		nmi_s1_reg <= i_nmi_req;
		nmi_s2_reg <= nmi_s1_reg;
		nmi_s3_reg <= nmi_s2_reg;
		nmi_filt_reg <= nmi_filt_next;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			page_reg <= CRS_PAGE_RST;
			nmi_arm_reg <= 1'b0;
			addr_valid_reg <= 1'b0;
			nmi_reg <= 1'b0;
		end else begin
			page_reg <= page_next;
			nmi_arm_reg <= nmi_arm_next;
			addr_valid_reg <= addr_valid_next;
			nmi_reg <= nmi_next;
		end
	end

	always_comb begin
		o_addr = addr_reg;
		o_addr_valid = addr_valid_reg;
		o_high = high_reg;
		o_low = low_reg;
		o_pair = {high_reg, low_reg};
		o_page = page_reg;
		o_first = first_reg;
		o_second = second_reg;
		o_soft = soft_reg;
		o_frame = frame_reg;
		o_fetch = fetch_reg;
		o_nmi = nmi_reg;
	end
endmodule

// File: verilog/crs_pkg.sv
package crs_pkg;
	localparam int unsigned CRS_BYTE_W = 8;
	localparam int unsigned CRS_WORD_W = 16;
	localparam logic [7:0] CRS_PAGE_RST = 8'h00;
	localparam logic [15:0] CRS_ONE = 16'h0001;
	localparam logic [15:0] CRS_TWO = 16'h0002;

	// Pointer select codes.
	typedef enum logic [2:0] {
		CRS_P_FIRST = 3'h0,
		CRS_P_SECOND = 3'h1,
		CRS_P_SOFT = 3'h2,
		CRS_P_FRAME = 3'h3,
		CRS_P_FETCH = 3'h4
	} crs_ptr_t;

	// Indexed adjust modes.
	typedef enum logic [2:0] {
		CRS_X_NONE = 3'h0,
		CRS_X_INC1 = 3'h1,
		CRS_X_INC2 = 3'h2,
		CRS_X_DEC1 = 3'h3,
		CRS_X_DEC2 = 3'h4
	} crs_adj_t;

	// Offset sources.
	typedef enum logic [1:0] {
		CRS_O_NONE = 2'h0,
		CRS_O_CONST = 2'h1,
		CRS_O_REG = 2'h2
	} crs_off_t;

	// Register write targets.
	typedef enum logic [3:0] {
		CRS_W_NONE = 4'h0,
		CRS_W_HIGH = 4'h1,
		CRS_W_LOW = 4'h2,
		CRS_W_PAIR = 4'h3,
		CRS_W_PAGE = 4'h4,
		CRS_W_FIRST = 4'h5,
		CRS_W_SECOND = 4'h6,
		CRS_W_SOFT = 4'h7,
		CRS_W_FRAME = 4'h8,
		CRS_W_FETCH = 4'h9
	} crs_wr_t;

	// Stack operation.
	typedef enum logic [1:0] {
		CRS_S_NONE = 2'h0,
		CRS_S_PUSH = 2'h1,
		CRS_S_PULL = 2'h2
	} crs_stk_t;
endpackage

// File: verilog/crs_ea_unit.sv
`timescale 1ns/1ps
module crs_ea_unit import crs_pkg::*; #(
	parameter int unsigned W = CRS_WORD_W
) (
	input wire logic [W-1:0] i_base,
	input wire crs_adj_t i_adj,
	input wire crs_off_t i_off_sel,
	input wire logic [W-1:0] i_const_off,
	input wire logic [W-1:0] i_reg_off,
	output logic [W-1:0] o_ea,
	output logic [W-1:0] o_wb,
	output logic o_wb_en
);
	logic [W-1:0] addr_base;
	logic [W-1:0] off;
	always_comb begin
		addr_base = i_base;
		o_wb = i_base;
		o_wb_en = 1'b0;
		off = '0;
		case (i_adj)
			CRS_X_INC1: begin
				o_wb = i_base + CRS_ONE;
				o_wb_en = 1'b1;
			end
			CRS_X_INC2: begin
				o_wb = i_base + CRS_TWO;
				o_wb_en = 1'b1;
			end
			CRS_X_DEC1: begin
				o_wb = i_base - CRS_ONE;
				addr_base = o_wb;
				o_wb_en = 1'b1;
			end
			CRS_X_DEC2: begin
				o_wb = i_base - CRS_TWO;
				addr_base = o_wb;
				o_wb_en = 1'b1;
			end
			default: begin
				o_wb_en = 1'b0;
			end
		endcase
		case (i_off_sel)
			CRS_O_CONST: off = i_const_off;
			CRS_O_REG: off = i_reg_off;
			default: off = '0;
		endcase
		o_ea = addr_base + off;
	end
endmodule

// File: verilog/crs_stack_unit.sv
`timescale 1ns/1ps
module crs_stack_unit import crs_pkg::*; #(
	parameter int unsigned W = CRS_WORD_W
) (
	input wire logic [W-1:0] i_sp,
	input wire crs_stk_t i_op,
	output logic [W-1:0] o_addr,
	output logic [W-1:0] o_sp_next,
	output logic o_sp_we
);
	always_comb begin
		o_addr = i_sp;
		o_sp_next = i_sp;
		o_sp_we = 1'b0;
		case (i_op)
			CRS_S_PUSH: begin
				o_sp_next = i_sp - CRS_ONE;
				o_addr = o_sp_next;
				o_sp_we = 1'b1;
			end
			CRS_S_PULL: begin
				o_sp_next = i_sp + CRS_ONE;
				o_sp_we = 1'b1;
			end
			default: begin
				o_sp_we = 1'b0;
			end
		endcase
	end
endmodule

// File: dv/crs_regset_props.sv
`timescale 1ns/1ps
module crs_regset_chk import crs_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire crs_wr_t i_wr_sel,
	input wire logic [15:0] i_wr_data,
	input wire logic i_direct,
	input wire logic [7:0] i_direct_low,
	input wire logic i_idx_en,
	input wire crs_ptr_t i_idx_ptr,
	input wire crs_adj_t i_idx_adj,
	input wire crs_off_t i_idx_off_sel,
	input wire crs_stk_t i_stk_op,
	input wire logic i_stk_explicit,
	input wire logic i_stk_frame,
	input wire logic i_nmi_req,
	input wire logic [15:0] o_addr,
	input wire logic o_addr_valid,
	input wire logic [15:0] o_pair,
	input wire logic [7:0] o_page,
	input wire logic [15:0] o_first,
	input wire logic [15:0] o_soft,
	input wire logic [15:0] o_frame,
	input wire logic o_nmi
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic seen_reg;
	wire logic sc = !i_direct && !i_idx_en && i_wr_sel == CRS_W_NONE;
	wire logic fr = sc && i_stk_frame && !i_stk_explicit;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) seen_reg <= 1'b0;
		else if (i_wr_sel == CRS_W_FRAME) seen_reg <= 1'b1;
	end
	AST_PAIR: assert property (i_wr_sel == CRS_W_PAIR |=> o_pair == $past(i_wr_data))
		else $error("pair wrong");
	AST_DIRECT: assert property (i_direct && i_wr_sel != CRS_W_PAGE |=>
		o_addr_valid && o_addr == {$past(o_page), $past(i_direct_low)}) else $error("direct");
	// Judged from the second edge in reset on, as the very first edge may precede the clear.
	AST_PAGE_RST: assert property (disable iff (1'b0)
		i_rst && $past(i_rst) |-> o_page == CRS_PAGE_RST) else $error("page reset");
	AST_PUSH: assert property (i_stk_op == CRS_S_PUSH && fr |=>
		o_addr_valid && o_addr == $past(o_frame) - CRS_ONE && o_frame == o_addr) else $error("push");
	AST_PULL: assert property (i_stk_op == CRS_S_PULL && fr |=>
		o_addr == $past(o_frame) && o_frame == $past(o_frame) + CRS_ONE) else $error("pull");
	AST_REFUSE: assert property (i_stk_op != CRS_S_NONE && sc && !i_stk_frame &&
		!i_stk_explicit |=> !o_addr_valid && $stable(o_frame) && $stable(o_soft))
		else $error("refuse");
	AST_DEC: assert property (i_idx_en && i_idx_ptr == CRS_P_FIRST && i_idx_adj == CRS_X_DEC1
		&& i_idx_off_sel == CRS_O_NONE && !i_direct && i_stk_op == CRS_S_NONE
		&& i_wr_sel == CRS_W_NONE |=> o_addr == $past(o_first) - CRS_ONE && o_first == o_addr)
		else $error("dec");
	// The request crosses a three-stage filter, so it shows four cycles late once steady.
	AST_NMI: assert property ($past(i_nmi_req, 4) == $past(i_nmi_req, 5) |->
		o_nmi == ($past(seen_reg) && $past(i_nmi_req, 4))) else $error("nmi gate");
endmodule

// File: dv/crs_regset_test.sv
`timescale 1ns/1ps
module crs_regset_test;
	import crs_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	crs_wr_t i_wr_sel = CRS_W_NONE;
	logic [15:0] i_wr_data = 16'h0000;
	logic i_direct = 1'b0;
	logic [7:0] i_direct_low = 8'h00;
	logic i_idx_en = 1'b0;
	crs_ptr_t i_idx_ptr = CRS_P_FIRST;
	crs_adj_t i_idx_adj = CRS_X_NONE;
	crs_off_t i_idx_off_sel = CRS_O_NONE;
	logic [15:0] i_idx_const = 16'h0010;
	logic [15:0] i_idx_regoff = 16'h0020;
	crs_stk_t i_stk_op = CRS_S_NONE;
	logic i_stk_explicit = 1'b0;
	logic i_stk_frame = 1'b0;
	logic i_fetch_adv = 1'b0;
	logic i_nmi_req = 1'b0;
	logic [15:0] o_addr, o_pair, o_first, o_second, o_soft, o_frame, o_fetch;
	logic [7:0] o_high, o_low, o_page;
	logic o_addr_valid, o_nmi;
	int error_cnt = 0;
	int total_checks = 0;
	crs_regset dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
		.i_direct(i_direct), .i_direct_low(i_direct_low), .i_idx_en(i_idx_en),
		.i_idx_ptr(i_idx_ptr), .i_idx_adj(i_idx_adj), .i_idx_off_sel(i_idx_off_sel),
		.i_idx_const(i_idx_const), .i_idx_regoff(i_idx_regoff), .i_stk_op(i_stk_op),
		.i_stk_explicit(i_stk_explicit), .i_stk_frame(i_stk_frame),
		.i_fetch_adv(i_fetch_adv), .i_nmi_req(i_nmi_req), .o_addr(o_addr),
		.o_addr_valid(o_addr_valid), .o_high(o_high), .o_low(o_low), .o_pair(o_pair),
		.o_page(o_page), .o_first(o_first), .o_second(o_second), .o_soft(o_soft),
		.o_frame(o_frame), .o_fetch(o_fetch), .o_nmi(o_nmi)
	);
	always #2 i_clk = ~i_clk;
	task give_verdict;
		if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask
	task go;
		@(negedge i_clk);
	endtask
	task rst;
		go();
		i_rst = 1'b1;
		repeat (20) go();
		chk("page", 16'h0000, {8'h00, o_page});
		i_rst = 1'b0;
	endtask
	task wr(input crs_wr_t s, input logic [15:0] d);
		go();
		i_wr_sel = s;
		i_wr_data = d;
		go();
		i_wr_sel = CRS_W_NONE;
	endtask
	task stk(input crs_stk_t op, input logic f, input logic x);
		go();
		i_stk_op = op;
		i_stk_frame = f;
		i_stk_explicit = x;
		go();
		i_stk_op = CRS_S_NONE;
	endtask
	task idx(input crs_ptr_t p, input crs_adj_t m, input crs_off_t o);
		go();
		i_idx_en = 1'b1;
		i_idx_ptr = p;
		i_idx_adj = m;
		i_idx_off_sel = o;
		go();
		i_idx_en = 1'b0;
	endtask
	function automatic logic [15:0] pv(input int p);
		return p == 0 ? o_first : p == 1 ? o_second : p == 2 ? o_soft : o_frame;
	endfunction
	task s_nmi_acc;
		i_nmi_req = 1'b1;
		// Long enough for the request to clear the input filter while still unarmed.
		repeat (6) go();
		chk("nmi", 16'h0000, {15'h0, o_nmi});
		wr(CRS_W_FRAME, 16'h0100);
		go();
		chk("nmi", 16'h0001, {15'h0, o_nmi});
		i_nmi_req = 1'b0;
		wr(CRS_W_PAIR, 16'h1234);
		chk("pair", 16'h1234, o_pair);
		wr(CRS_W_HIGH, 16'h0056);
		chk("pair", 16'h5634, o_pair);
		wr(CRS_W_LOW, 16'h0078);
		chk("pair", 16'h5678, {o_high, o_low});
	endtask
	task s_direct;
		wr(CRS_W_PAGE, 16'h00a5);
		go();
		i_direct = 1'b1;
		i_direct_low = 8'h3c;
		go();
		i_direct = 1'b0;
		chk("daddr", 16'ha53c, o_addr);
		chk("dvalid", 16'h0001, {15'h0, o_addr_valid});
		rst();
		go();
		i_direct = 1'b1;
		go();
		i_direct = 1'b0;
		chk("daddr", 16'h003c, o_addr);
	endtask
	task s_stack;
		wr(CRS_W_FRAME, 16'h0100);
		wr(CRS_W_SOFT, 16'h0200);
		go();
		i_stk_op = CRS_S_PUSH;
		i_stk_frame = 1'b1;
		go();
		chk("push", 16'h00ff, o_frame);
		go();
		i_stk_op = CRS_S_NONE;
		chk("push", 16'h00fe, o_addr);
		chk("soft", 16'h0200, o_soft);
		stk(CRS_S_PULL, 1'b1, 1'b0);
		chk("pull", 16'h00fe, o_addr);
		chk("pull", 16'h00ff, o_frame);
		stk(CRS_S_PUSH, 1'b0, 1'b1);
		chk("spush", 16'h01ff, o_soft);
		stk(CRS_S_PULL, 1'b0, 1'b1);
		chk("spull", 16'h01ff, o_addr);
		stk(CRS_S_PUSH, 1'b0, 1'b0);
		chk("valid", 16'h0000, {15'h0, o_addr_valid});
		chk("soft", 16'h0200, o_soft);
	endtask
	task s_index;
		crs_adj_t ms[5] = '{CRS_X_NONE, CRS_X_INC1, CRS_X_INC2, CRS_X_DEC1, CRS_X_DEC2};
		crs_off_t os[5] = '{CRS_O_NONE, CRS_O_REG, CRS_O_CONST, CRS_O_NONE, CRS_O_CONST};
		logic [15:0] st[5] = '{16'h0000, 16'h0001, 16'h0002, 16'hffff, 16'hfffe};
		logic [15:0] ov[5] = '{16'h0000, 16'h0020, 16'h0010, 16'h0000, 16'h0010};
		logic [15:0] b;
		logic [15:0] n;
		for (int p = 0; p < 4; p++) begin
			b = 16'(p + 1) << 12;
			for (int k = 0; k < 5; k++) begin
				n = b + st[k];
				wr(crs_wr_t'(p + 5), b);
				idx(crs_ptr_t'(p), ms[k], os[k]);
				chk("iaddr", (k > 2 ? n : b) + ov[k], o_addr);
				chk("iptr", n, pv(p));
			end
		end
		wr(CRS_W_FETCH, 16'h8000);
		i_fetch_adv = 1'b1;
		go();
		i_fetch_adv = 1'b0;
		idx(CRS_P_FETCH, CRS_X_NONE, CRS_O_CONST);
		chk("fetch", 16'h8011, o_addr);
		chk("fptr", 16'h8001, o_fetch);
	endtask
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		rst();
		s_nmi_acc();
		s_direct();
		s_stack();
		s_index();
		give_verdict();
	end
endmodule
bind crs_regset crs_regset_chk chk_u (
	.i_clk(i_clk), .i_rst(i_rst), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
	.i_direct(i_direct), .i_direct_low(i_direct_low), .i_idx_en(i_idx_en),
	.i_idx_ptr(i_idx_ptr), .i_idx_adj(i_idx_adj), .i_idx_off_sel(i_idx_off_sel),
	.i_stk_op(i_stk_op), .i_stk_explicit(i_stk_explicit), .i_stk_frame(i_stk_frame),
	.i_nmi_req(i_nmi_req), .o_addr(o_addr), .o_addr_valid(o_addr_valid),
	.o_pair(o_pair), .o_page(o_page), .o_first(o_first), .o_soft(o_soft),
	.o_frame(o_frame), .o_nmi(o_nmi)
);
